// ---- verilog/uart_channel_custom.sv ----
// channel custom control: wide mode, receive forwarding, serial state notification
`timescale 1ns/1ns
`include "uart_chan_defs.svh"
module uart_channel_custom (
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   // ****************************************************************
   // AHB-Lite slave
   // ****************************************************************
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   output logic             irq,
   // ****************************************************************
   // channel side
   // ****************************************************************
   input  wire logic [23:0] baudRate,
   output logic             wideModeEn,
   output logic             promptFwdEn,
   input  wire logic        rxByteIn,
   input  wire logic        charTick,
   input  wire logic [6:0]  rxFifoCount,
   input  wire logic        bulkInReq,
   output logic             bulkInEligible,
   output logic             bulkInGrant,
   output logic [6:0]       bulkInCount,
   // ****************************************************************
   // line and pin states for the notification
   // ****************************************************************
   input  wire logic        errOverrun,
   input  wire logic        errParity,
   input  wire logic        errFraming,
   input  wire logic        ringState,
   input  wire logic        breakState,
   input  wire logic        dsrState,
   input  wire logic        cdState,
   input  wire logic [5:0]  gpioIn,
   input  wire logic        intInToken,
   output logic             intInNak,
   output logic             noteValid,
   output logic [7:0]       noteByte,
   output logic             noteLast,
   input  wire logic        noteReady
);
   uart_chan_pkg::chan_state_t state_reg;
   uart_chan_pkg::chan_state_t state_next;
   logic [5:0]                 addrIdx;
   logic                       addrTaken;
   logic [6:0]                 lineNow;
   logic                       lineChg;
   logic                       gpioChg;
   logic [15:0]                fieldNow;
   logic                       startPkt;
   logic                       byteTaken;
   logic                       belowLimit;
   logic                       eligible;

   // ****************************************************************
   // helpers
   // ****************************************************************
   // off-window or unaligned: unmapped
   function automatic logic [5:0] regIdx(input logic [31:0] a);
      if (a[31:8] != 24'h000000 || a[1:0] != 2'b00) begin
         return `IDX_NONE;
      end
      return a[7:2];
   endfunction

   // upper status byte from the report select and pin levels
   function automatic logic [7:0] packHigh(input logic [7:0] sel, input logic [5:0] pin);
      logic [7:0] h;
      h = 8'h00;
      h[0] = sel[0] & pin[1];
      h[1] = sel[1] & pin[2];
      h[3] = sel[3] & pin[0];
      h[4] = sel[4] & pin[3];
      h[5] = sel[5] & pin[4];
      h[6] = sel[6] & pin[5];
      return h;
   endfunction

   function automatic logic [7:0] byteAt(input logic [3:0] i, input logic [15:0] d);
      case (i)
         4'h0:    return `NOTE_REQ_TYPE;
         4'h1:    return `NOTE_SERIAL_ST;
         4'h2:    return 8'(`NOTE_VALUE);
         4'h3:    return 8'(`NOTE_VALUE >> 8);
         4'h4:    return `NOTE_IFACE_NUM;
         4'h5:    return 8'h00;
         4'h6:    return 8'(`NOTE_LENGTH);
         4'h7:    return 8'(`NOTE_LENGTH >> 8);
         4'h8:    return d[7:0];
         4'h9:    return d[15:8];
         default: return 8'h00;
      endcase
   endfunction

   // ****************************************************************
   // receive forwarding
   // ****************************************************************
   rx_forward_timer fwd (
      .core_clk     (core_clk),
      .rst_n        (rst_n),
      .promptEn     (state_reg.lowLatEn),
      .rxByteIn     (rxByteIn),
      .charTick     (charTick),
      .fifoCount    (rxFifoCount),
      .bulkInReq    (bulkInReq),
      .dataEligible (eligible),
      .grantValid   (bulkInGrant),
      .grantCount   (bulkInCount)
   );

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      state_next = state_reg;
      addrIdx = regIdx(haddr);
      addrTaken = hsel && htrans[1] && hready;
      belowLimit = (baudRate < `LOW_LAT_BAUD);

      // data phase of a write commits the register
      if (state_reg.dataPhase && state_reg.dataWrite) begin
         case (state_reg.dataIdx)
            `IDX_WIDE:     state_next.wideEn = hwdata[`WIDE_EN_BIT];
            `IDX_LOWLAT:   state_next.lowLatEn = hwdata[`LOWLAT_EN_BIT];
            `IDX_GPIOSEL:  state_next.gpioSel = hwdata[7:0] & `GPIOSEL_WMASK;
            `IDX_GPIOMASK: state_next.gpioMask = hwdata[5:0];
            `IDX_IRQMASK:  state_next.irqMask = hwdata[2:0];
            default:       state_next.dataPhase = 1'b0;
         endcase
      end
      // slow links always forward promptly
      if (belowLimit) begin
         state_next.lowLatEn = 1'b1;
      end

      // ****************************************************************
      // notification field and change detection
      // ****************************************************************
      lineNow = {errOverrun, errParity, errFraming, ringState,
                 breakState, dsrState, cdState};
      fieldNow = {packHigh(state_reg.gpioSel, gpioIn), 1'b0, lineNow};
      lineChg = (lineNow != state_reg.lastLine);
      gpioChg = ((gpioIn ^ state_reg.lastGpio) & ~state_reg.gpioMask) != 6'h00;
      state_next.lastLine = lineNow;
      state_next.lastGpio = gpioIn;

      startPkt = intInToken && state_reg.notePending
                 && (state_reg.noteState == uart_chan_pkg::NOTE_IDLE);
      intInNak = intInToken && !startPkt;
      byteTaken = state_reg.noteValid && noteReady;
      // change at start stays queued
      state_next.notePending = (state_reg.notePending && !startPkt) || lineChg || gpioChg;

      case (state_reg.noteState)
         uart_chan_pkg::NOTE_IDLE: begin
            if (startPkt) begin
               state_next.noteState = uart_chan_pkg::NOTE_SEND;
               state_next.noteData = fieldNow;
               state_next.byteIdx = 4'h0;
               state_next.noteByte = byteAt(4'h0, fieldNow);
               state_next.noteValid = 1'b1;
               state_next.noteLast = 1'b0;
            end
         end
         uart_chan_pkg::NOTE_SEND: begin
            if (byteTaken) begin
               if (state_reg.noteLast) begin
                  state_next.noteState = uart_chan_pkg::NOTE_IDLE;
                  state_next.noteValid = 1'b0;
                  state_next.noteLast = 1'b0;
               end else begin
                  state_next.byteIdx = state_reg.byteIdx + 4'h1;
                  state_next.noteByte = byteAt(state_next.byteIdx, state_reg.noteData);
                  state_next.noteLast = (state_next.byteIdx == `NOTE_LAST_BYTE);
               end
            end
         end
         default: begin
            state_next.noteState = uart_chan_pkg::NOTE_IDLE;
            state_next.noteValid = 1'b0;
         end
      endcase

      // ****************************************************************
      // interrupt status; a read clears, a new event wins
      // ****************************************************************
      if (addrTaken && !hwrite && addrIdx == `IDX_IRQSTAT) begin
         state_next.irqStatus = 3'h0;
      end
      state_next.irqStatus[`IRQ_GPIO_BIT] = state_next.irqStatus[`IRQ_GPIO_BIT] | gpioChg;
      state_next.irqStatus[`IRQ_LINE_BIT] = state_next.irqStatus[`IRQ_LINE_BIT] | lineChg;
      state_next.irqStatus[`IRQ_SENT_BIT] = state_next.irqStatus[`IRQ_SENT_BIT]
                                            | (byteTaken && state_reg.noteLast);

      // ****************************************************************
      // address phase: read data registered from post-write values
      // ****************************************************************
      state_next.dataPhase = addrTaken;
      state_next.dataWrite = addrTaken && hwrite;
      state_next.dataIdx = addrIdx;
      if (addrTaken && !hwrite) begin
         case (addrIdx)
            `IDX_WIDE:     state_next.rdata = {31'h0, state_next.wideEn};
            `IDX_LOWLAT:   state_next.rdata = {31'h0, state_next.lowLatEn};
            `IDX_GPIOSEL:  state_next.rdata = {24'h0, state_next.gpioSel};
            `IDX_GPIOMASK: state_next.rdata = {26'h0, state_next.gpioMask};
            `IDX_IRQSTAT:  state_next.rdata = {29'h0, state_reg.irqStatus};
            `IDX_IRQMASK:  state_next.rdata = {29'h0, state_next.irqMask};
            `IDX_NOTEDATA: state_next.rdata = {16'h0, fieldNow};
            `IDX_FWDSTAT:  state_next.rdata = {23'h0, rxFifoCount, eligible, state_reg.notePending};
            default:       state_next.rdata = 32'h0;
         endcase
      end
   end

   // ****************************************************************
   // state register
   // ****************************************************************
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         state_reg <= '0;
         state_reg.wideEn <= `RST_WIDE;
         state_reg.lowLatEn <= `RST_LOWLAT;
         state_reg.gpioSel <= `RST_GPIOSEL;
         state_reg.gpioMask <= `RST_GPIOMASK;
         state_reg.irqMask <= `RST_IRQMASK;
         state_reg.noteState <= uart_chan_pkg::NOTE_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = state_reg.rdata;
   assign irq = (state_reg.irqStatus & state_reg.irqMask) != 3'h0;
   assign wideModeEn = state_reg.wideEn;
   assign promptFwdEn = state_reg.lowLatEn;
   assign bulkInEligible = eligible;
   assign noteValid = state_reg.noteValid;
   assign noteByte = state_reg.noteByte;
   assign noteLast = state_reg.noteLast;
endmodule

// ---- verilog/uart_chan_defs.svh ----
// constants for the per-channel custom control and notification block
//
// Notes on behaviour
// - wide enable clear: normal formats; set: wide
// - baud below 46921 forces prompt forwarding on
// - forwarding off: wait 64 bytes or 3-character timeout
// - forwarding on: next bulk IN takes everything
// - report select bits map to GPIO1,2,0,3,4,5
// - packet bytes 0,1: A1 then 20
// - wValue zero, wIndex interface number zero
// - wLength two, data field at byte 8
// - data D6..D2: overrun, parity, framing, ring, break
// - data D1 DSR, D0 carrier detect, live
// - upper byte: GPIO5,4,3,0 at D14..D11, GPIO2,1 at D9,D8, D15 and D10 zero
// - unmasked GPIO change queues a packet
`ifndef UART_CHAN_DEFS_SVH
`define UART_CHAN_DEFS_SVH

// ****************************************
// register indices (byte address is four times the index)
// ****************************************
`define IDX_WIDE        6'h03
`define IDX_LOWLAT      6'h04
`define IDX_GPIOSEL     6'h06
`define IDX_GPIOMASK    6'h07
`define IDX_IRQSTAT     6'h08
`define IDX_IRQMASK     6'h09
`define IDX_NOTEDATA    6'h0A
`define IDX_FWDSTAT     6'h0B
`define IDX_NONE        6'h3F

// ****************************************
// field positions, write masks, reset values
// ****************************************
`define WIDE_EN_BIT     0
`define LOWLAT_EN_BIT   0
`define GPIOSEL_WMASK   8'h7B
`define RST_WIDE        1'b0
`define RST_LOWLAT      1'b0
`define RST_GPIOSEL     8'h00
`define RST_GPIOMASK    6'h3F
`define RST_IRQMASK     3'h0
`define IRQ_GPIO_BIT    0
`define IRQ_LINE_BIT    1
`define IRQ_SENT_BIT    2

// ****************************************
// forwarding and notification figures
// ****************************************
`define LOW_LAT_BAUD    24'd46921
`define MAX_PKT_BYTES   7'd64
`define RX_TIMEOUT_CHR  2'd3
`define NOTE_REQ_TYPE   8'hA1
`define NOTE_SERIAL_ST  8'h20
`define NOTE_VALUE      16'h0000
`define NOTE_IFACE_NUM  8'h00
`define NOTE_LENGTH     16'h0002
`define NOTE_LAST_BYTE  4'h9

`endif

// ---- verilog/uart_chan_pkg.sv ----
// types shared by the channel control modules
package uart_chan_pkg;

   typedef enum logic [0:0] {NOTE_IDLE, NOTE_SEND} note_state_t;

   typedef struct packed {
      logic        wideEn;
      logic        lowLatEn;
      logic [7:0]  gpioSel;
      logic [5:0]  gpioMask;
      logic [2:0]  irqStatus;
      logic [2:0]  irqMask;
      logic        dataPhase;
      logic        dataWrite;
      logic [5:0]  dataIdx;
      logic [31:0] rdata;
      note_state_t noteState;
      logic        notePending;
      logic [3:0]  byteIdx;
      logic [15:0] noteData;
      logic [6:0]  lastLine;
      logic [5:0]  lastGpio;
      logic [7:0]  noteByte;
      logic        noteValid;
      logic        noteLast;
   } chan_state_t;

   typedef struct packed {
      logic [1:0] idleChars;
      logic       grantValid;
      logic [6:0] grantCount;
   } fwd_state_t;

endpackage

// ---- verilog/rx_forward_timer.sv ----
// decides when held receive bytes are released on a bulk IN request
`timescale 1ns/1ns
`include "uart_chan_defs.svh"
module rx_forward_timer (
   input  wire logic       core_clk,
   input  wire logic       rst_n,
   input  wire logic       promptEn,
   input  wire logic       rxByteIn,
   input  wire logic       charTick,
   input  wire logic [6:0] fifoCount,
   input  wire logic       bulkInReq,
   output logic            dataEligible,
   output logic            grantValid,
   output logic [6:0]      grantCount
);
   uart_chan_pkg::fwd_state_t state_reg;
   uart_chan_pkg::fwd_state_t state_next;
   logic                      timedOut;
   logic                      hasData;

   always_comb begin
      state_next = state_reg;
      hasData = (fifoCount != 7'h00);
      timedOut = (state_reg.idleChars >= `RX_TIMEOUT_CHR);
      // fresh byte restarts the silence count
      if (rxByteIn || !hasData) begin
         state_next.idleChars = 2'h0;
      end else if (charTick && !timedOut) begin
         state_next.idleChars = state_reg.idleChars + 2'h1;
      end
      if (promptEn) begin
         dataEligible = hasData;
      end else begin
         dataEligible = (fifoCount >= `MAX_PKT_BYTES) || (timedOut && hasData);
      end
      state_next.grantValid = bulkInReq;
      state_next.grantCount = 7'h00;
      if (bulkInReq) begin
         if (promptEn) begin
            state_next.grantCount = fifoCount;
         end else if (dataEligible) begin
            state_next.grantCount = (fifoCount >= `MAX_PKT_BYTES) ? `MAX_PKT_BYTES
                                                                  : fifoCount;
         end
         state_next.idleChars = 2'h0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign grantValid = state_reg.grantValid;
   assign grantCount = state_reg.grantCount;
endmodule

// ---- verif/uart_channel_custom_asserts.sv ----
// port checker for the channel control block
`timescale 1ns/1ns
`include "uart_chan_defs.svh"
module uart_channel_custom_asserts (
   input wire logic        core_clk,
   input wire logic        rst_n,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [23:0] baudRate,
   input wire logic        promptFwdEn,
   input wire logic [6:0]  rxFifoCount,
   input wire logic        bulkInReq,
   input wire logic        bulkInEligible,
   input wire logic        bulkInGrant,
   input wire logic [6:0]  bulkInCount,
   input wire logic        intInToken,
   input wire logic        intInNak,
   input wire logic        noteValid,
   input wire logic [7:0]  noteByte,
   input wire logic        noteLast,
   input wire logic        noteReady
);
   logic [3:0] byteIdx;

   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   // ****************************************
   // packet byte position, counted from accepted bytes
   // ****************************************
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         byteIdx <= 4'h0;
      end else if (noteValid && noteReady) begin
         byteIdx <= noteLast ? 4'h0 : byteIdx + 4'h1;
      end
   end

   function automatic logic [7:0] hdrByte(input logic [3:0] i);
      case (i)
         4'h0: hdrByte = 8'hA1;
         4'h1: hdrByte = 8'h20;
         4'h6: hdrByte = 8'h02;
         default: hdrByte = 8'h00;
      endcase
   endfunction

   sequence sTokenTaken;
      intInToken && !intInNak;
   endsequence
   sequence sFirstByte;
      noteValid && noteByte == 8'hA1 && byteIdx == 4'h0;
   endsequence

   // ****************************************
   // assertions
   // ****************************************
   AST_BUS_OKAY: assert property (hreadyout && !hresp)
      else $error("bus not okay");
   AST_SLOW_BAUD_FORCE: assert property ($past(rst_n) && $past(baudRate) < `LOW_LAT_BAUD
      && baudRate < `LOW_LAT_BAUD |-> promptFwdEn) else $error("no force");
   AST_GRANT_FOLLOWS: assert property (bulkInReq |=> bulkInGrant)
      else $error("no grant");
   AST_NO_STRAY_GRANT: assert property (!bulkInReq |=> !bulkInGrant && bulkInCount == 7'h00)
      else $error("stray grant");
   AST_PROMPT_ALL: assert property (bulkInReq && promptFwdEn |=>
      bulkInCount == $past(rxFifoCount)) else $error("prompt count");
   AST_FULL_PACKET: assert property (bulkInReq && !promptFwdEn
      && rxFifoCount >= `MAX_PKT_BYTES |=> bulkInCount == `MAX_PKT_BYTES)
      else $error("full packet");
   AST_HELD_BYTES: assert property (bulkInReq && !bulkInEligible |=> bulkInCount == 7'h00)
      else $error("early release");
   AST_NOTE_OPEN: assert property (sTokenTaken |=> sFirstByte)
      else $error("bad open");
   AST_HDR_TYPE: assert property (noteValid && byteIdx <= 4'h1 |->
      noteByte == hdrByte(byteIdx)) else $error("bad type byte");
   AST_HDR_VALUE_INDEX: assert property (noteValid && byteIdx >= 4'h2 && byteIdx <= 4'h5
      |-> noteByte == 8'h00) else $error("bad index");
   AST_HDR_LENGTH: assert property (noteValid && (byteIdx == 4'h6 || byteIdx == 4'h7)
      |-> noteByte == hdrByte(byteIdx)) else $error("bad length byte");
   AST_LAST_TENTH: assert property (noteValid |-> noteLast == (byteIdx == 4'h9))
      else $error("bad last");
   AST_NOTE_HOLD: assert property (noteValid && !noteReady |=>
      noteValid && $stable(noteByte) && $stable(noteLast)) else $error("byte not held");
   AST_NAK_BUSY: assert property (intInToken && noteValid |-> intInNak)
      else $error("mid-packet token");
endmodule

bind uart_channel_custom uart_channel_custom_asserts i_chk (
   .core_clk(core_clk), .rst_n(rst_n), .hreadyout(hreadyout), .hresp(hresp),
   .baudRate(baudRate), .promptFwdEn(promptFwdEn), .rxFifoCount(rxFifoCount),
   .bulkInReq(bulkInReq), .bulkInEligible(bulkInEligible), .bulkInGrant(bulkInGrant),
   .bulkInCount(bulkInCount), .intInToken(intInToken), .intInNak(intInNak),
   .noteValid(noteValid), .noteByte(noteByte), .noteLast(noteLast), .noteReady(noteReady)
);

// ---- verif/usb_host_model.sv ----
// host side model: bulk IN requests and interrupt IN tokens
`timescale 1ns/1ns
module usb_host_model (
   input  wire logic       core_clk,
   input  wire logic       bulkInGrant,
   input  wire logic [6:0] bulkInCount,
   input  wire logic       intInNak,
   input  wire logic       noteValid,
   input  wire logic [7:0] noteByte,
   input  wire logic       noteLast,
   output logic            bulkInReq,
   output logic            intInToken,
   output logic            noteReady
);
   logic [7:0] pkt [10];
   logic       gotNak;
   int         nBytes;

   initial begin
      bulkInReq = 1'b0;
      intInToken = 1'b0;
      noteReady = 1'b0;
   end

   task automatic bulkIn(output logic g, output logic [6:0] c);
      @(posedge core_clk);
      bulkInReq <= 1'b1;
      @(posedge core_clk);
      bulkInReq <= 1'b0;
      @(posedge core_clk);
      g = bulkInGrant;
      c = bulkInCount;
   endtask

   // stall: every byte after the first held across a refused edge
   task automatic fetchNote(input bit stall);
      nBytes = 0;
      @(posedge core_clk);
      intInToken <= 1'b1;
      @(posedge core_clk);
      gotNak = intInNak;
      intInToken <= 1'b0;
      noteReady <= !intInNak;
      for (int i = 0; i < 40 && !gotNak && nBytes < 10; i++) begin
         @(posedge core_clk);
         if (noteValid && noteReady) begin
            pkt[nBytes] = noteByte;
            nBytes++;
         end
         noteReady <= (nBytes < 10) && (!stall || !noteReady);
      end
   endtask
endmodule

// ---- verif/tb_uart_channel_custom.sv ----
// self-checking bench for the channel control block
`timescale 1ns/1ns
`include "uart_chan_defs.svh"
module tb_uart_channel_custom;
   logic        core_clk, rst_n, hsel, hwrite, hreadyout, hresp, irq;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [23:0] baudRate;
   logic        wideModeEn, promptFwdEn, rxByteIn, charTick;
   logic [6:0]  rxFifoCount, bulkInCount, line;
   logic        bulkInReq, bulkInEligible, bulkInGrant, intInToken, intInNak;
   logic        noteValid, noteLast, noteReady;
   logic [7:0]  noteByte;
   logic [5:0]  gpioIn;
   int          n_mismatch, check_count;

   uart_channel_custom i_dut (
      .core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq), .baudRate(baudRate),
      .wideModeEn(wideModeEn), .promptFwdEn(promptFwdEn), .rxByteIn(rxByteIn),
      .charTick(charTick), .rxFifoCount(rxFifoCount), .bulkInReq(bulkInReq),
      .bulkInEligible(bulkInEligible), .bulkInGrant(bulkInGrant), .bulkInCount(bulkInCount),
      .errOverrun(line[6]), .errParity(line[5]), .errFraming(line[4]), .ringState(line[3]),
      .breakState(line[2]), .dsrState(line[1]), .cdState(line[0]), .gpioIn(gpioIn),
      .intInToken(intInToken), .intInNak(intInNak), .noteValid(noteValid),
      .noteByte(noteByte), .noteLast(noteLast), .noteReady(noteReady));

   usb_host_model i_host (
      .core_clk(core_clk), .bulkInGrant(bulkInGrant), .bulkInCount(bulkInCount),
      .intInNak(intInNak), .noteValid(noteValid), .noteByte(noteByte), .noteLast(noteLast),
      .bulkInReq(bulkInReq), .intInToken(intInToken), .noteReady(noteReady));

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // ****************************************
   // shared tasks
   // ****************************************
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic edgeReady();
      for (int i = 0; i < 20; i++) begin
         @(posedge core_clk);
         if (hreadyout === 1'b1) return;
      end
      n_mismatch++;
      summarize();
   endtask

   task automatic busXfer(input logic [5:0] idx, input logic wr, input logic [31:0] wd,
                          output logic [31:0] rd);
      @(posedge core_clk);
      hsel <= 1'b1;
      haddr <= {24'h000000, idx, 2'b00};
      htrans <= 2'b10;
      hwrite <= wr;
      edgeReady();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      edgeReady();
      rd = hrdata;
   endtask

   // lets the stored value reach the ports
   task automatic wr(input logic [5:0] idx, input logic [31:0] d);
      logic [31:0] v;
      busXfer(idx, 1'b1, d, v);
      @(posedge core_clk);
   endtask

   task automatic rd(input logic [5:0] idx, input logic [31:0] exp);
      logic [31:0] v;
      busXfer(idx, 1'b0, 32'h0, v);
      check(v, exp);
   endtask

   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge core_clk);
         charTick <= 1'b1;
         @(posedge core_clk);
         charTick <= 1'b0;
      end
   endtask

   task automatic settle();
      repeat (3) @(posedge core_clk);
   endtask

   task automatic bulk(input logic [6:0] exp);
      logic       g;
      logic [6:0] c;
      i_host.bulkIn(g, c);
      check({31'h0, g}, 32'h1);
      check({25'h0, c}, {25'h0, exp});
   endtask

   task automatic nakSeen();
      i_host.fetchNote(1'b0);
      check({31'h0, i_host.gotNak}, 32'h1);
   endtask

   task automatic checkNote(input logic [7:0] sel, input bit stall);
      logic [7:0] hi;
      logic [7:0] exp [10];
      hi = {1'b0, gpioIn[5] & sel[6], gpioIn[4] & sel[5], gpioIn[3] & sel[4],
            gpioIn[0] & sel[3], 1'b0, gpioIn[2] & sel[1], gpioIn[1] & sel[0]};
      exp = '{8'hA1, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, {1'b0, line}, hi};
      i_host.fetchNote(stall);
      check({31'h0, i_host.gotNak}, 32'h0);
      check(32'(i_host.nBytes), 32'd10);
      if (i_host.nBytes != 10) summarize();
      for (int i = 0; i < 10; i++) begin
         check({24'h0, i_host.pkt[i]}, {24'h0, exp[i]});
      end
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      n_mismatch = 0;
      check_count = 0;
      rst_n = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      baudRate = 24'd115200;
      rxByteIn = 1'b0;
      charTick = 1'b0;
      rxFifoCount = 7'h00;
      line = 7'h00;
      gpioIn = 6'h00;
      repeat (10) @(posedge core_clk);
      rst_n <= 1'b1;
      rd(`IDX_WIDE, 32'h0);
      rd(`IDX_LOWLAT, 32'h0);
      rd(`IDX_GPIOSEL, 32'h0);
      rd(`IDX_GPIOMASK, 32'h3F);
      wr(`IDX_NONE, 32'h5A);
      rd(`IDX_NONE, 32'h0);
      $display("test reset done");
      wr(`IDX_WIDE, 32'h1);
      check({31'h0, wideModeEn}, 32'h1);
      wr(`IDX_WIDE, 32'h0);
      check({31'h0, wideModeEn}, 32'h0);
      wr(`IDX_GPIOSEL, 32'h7B);
      rd(`IDX_GPIOSEL, 32'h7B);
      $display("test registers done");
      baudRate <= 24'd46920;
      settle();
      check({31'h0, promptFwdEn}, 32'h1);
      wr(`IDX_LOWLAT, 32'h0);
      rd(`IDX_LOWLAT, 32'h1);
      baudRate <= 24'd46921;
      wr(`IDX_LOWLAT, 32'h0);
      check({31'h0, promptFwdEn}, 32'h0);
      wr(`IDX_LOWLAT, 32'h1);
      rd(`IDX_LOWLAT, 32'h1);
      rxFifoCount <= 7'd5;
      bulk(7'd5);
      wr(`IDX_LOWLAT, 32'h0);
      rxFifoCount <= 7'd10;
      @(posedge core_clk);
      rxByteIn <= 1'b1;
      @(posedge core_clk);
      rxByteIn <= 1'b0;
      bulk(7'd0);
      ticks(2);
      bulk(7'd0);
      ticks(3);
      bulk(7'd10);
      rxFifoCount <= 7'd70;
      bulk(7'd64);
      rd(`IDX_FWDSTAT, 32'h11A);
      $display("test forwarding done");
      wr(`IDX_IRQMASK, 32'h7);
      gpioIn <= 6'h15;
      settle();
      check({31'h0, irq}, 32'h0);
      nakSeen();
      wr(`IDX_GPIOMASK, 32'h0);
      gpioIn <= 6'h2A;
      settle();
      check({31'h0, irq}, 32'h1);
      wr(`IDX_IRQMASK, 32'h0);
      check({31'h0, irq}, 32'h0);
      wr(`IDX_IRQMASK, 32'h7);
      rd(`IDX_IRQSTAT, 32'h1);
      line <= 7'h51;
      settle();
      checkNote(8'h7B, 1'b1);
      rd(`IDX_IRQSTAT, 32'h6);
      check({31'h0, irq}, 32'h0);
      nakSeen();
      wr(`IDX_GPIOSEL, 32'h09);
      line <= 7'h2E;
      settle();
      checkNote(8'h09, 1'b0);
      rd(`IDX_NOTEDATA, 32'h012E);
      wr(`IDX_GPIOMASK, 32'h3E);
      gpioIn <= 6'h28;
      settle();
      nakSeen();
      gpioIn <= 6'h29;
      settle();
      checkNote(8'h09, 1'b1);
      $display("test notification done");
      summarize();
   end
endmodule
